/* File: core/dcc_top.sv */
// Disconnector control: command gating, command pulses, position filter, counter
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defines.svh"
// Function
// - Accepted open drives timed open pulse
// - Accepted close drives timed close pulse
// - Each operation gives fixed 150 ms pulse
// - Closed indication is filtered closed input
// - Opened indication is filtered open input
// - Counter increments on operation pulse rising
// - Counter reset request clears the counter, or loads one on a same-cycle rising
// - Two-bit position code from both inputs
// - Event on each position code change
// - Origin permission gates local or remote commands
// - Direction permit gates open or close
// - Timing within five percent or 15 ms
// - Pulse 100..60000 ms, early end after minimum
// - Inhibit refuses every operation
// - Unsettled inputs report intermediate after timeout
// - Enhanced model flags missing position change
module dcc_top
  import dcc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `DCC_MS_NS / `DCC_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic clock_en,
  input wire logic arst_n,
  // Commands from panel and station controller
  input wire dcc_cmd_t local_cmd,
  input wire dcc_cmd_t remote_cmd,
  // Permissions and interlocks
  input wire logic local_permit,
  input wire logic remote_permit,
  input wire logic open_permit,
  input wire logic close_permit,
  input wire logic inhibit_input,
  // Position contacts
  input wire logic open_position_input,
  input wire logic closed_position_input,
  // Settings
  input wire logic [15:0] pulse_duration_ms,
  input wire logic [15:0] max_intermediate_ms,
  input wire logic [15:0] max_operating_ms,
  input wire logic enhanced_model,
  input wire logic counter_reset,
  // Switch commands
  output logic open_command_pulse,
  output logic close_command_pulse,
  output logic operation_pulse,
  // Position reporting
  output logic opened_indication,
  output logic closed_indication,
  output dcc_pos_t position_state_code,
  output logic position_event,
  output dcc_pos_t position_event_code,
  // Status
  output logic cmd_accepted,
  output logic cmd_refused,
  output logic invalid_position_error,
  output logic [31:0] operation_count
);
  logic rst_meta_q;
  logic rst_n_q;
  dcc_state_t state_q;
  dcc_pos_t pos_q, pos_d, raw_prev_q, target_q;
  dcc_pos_t raw_pos;
  dcc_cmd_t cmd;
  logic open_q, close_q, opened_q, closed_q, event_q, acc_q, ref_q, err_q, op_prev_q;
  dcc_pos_t event_code_q;
  logic [31:0] count_q;
  logic origin_ok, dir_ok, accept, acc_open, acc_close, early_done, pulse_end, op_rise;
  logic pulse_exp, inter_exp, optime_exp, optime_running, oper_running;
  logic [15:0] pulse_elapsed;

  // Reset is released through two flops
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Local panel takes precedence when both origins request together
  assign cmd = local_cmd.valid ? local_cmd : remote_cmd;
  assign origin_ok = local_cmd.valid ? local_permit : (remote_cmd.valid & remote_permit);
  assign dir_ok = cmd.close ? close_permit : open_permit;
  assign accept = cmd.valid & origin_ok & dir_ok & ~inhibit_input
                  & (state_q == DCC_ST_IDLE) & clock_en;
  assign acc_open = accept & ~cmd.close;
  assign acc_close = accept & cmd.close;
  assign early_done = (pos_q == target_q) & (pulse_elapsed >= `DCC_PULSE_MIN_MS);
  assign pulse_end = (state_q == DCC_ST_PULSE) & (pulse_exp | early_done);

  dcc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_pulse_tmr (
    .clock(clock), .clock_en(clock_en), .rst_n(rst_n_q),
    .start(accept), .stop(pulse_end & ~pulse_exp),
    .limit_ms(dcc_clamp_ms(pulse_duration_ms, `DCC_PULSE_MIN_MS, `DCC_PULSE_MAX_MS,
                           `DCC_PULSE_DEF_MS)),
    .running(), .elapsed_ms(pulse_elapsed), .expired(pulse_exp)
  );

  // Command pulse state machine
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= DCC_ST_IDLE;
      open_q <= 1'b0;
      close_q <= 1'b0;
      target_q <= DCC_POS_INTERMEDIATE;
    end
    else if (clock_en)
    begin
      case (state_q)
        DCC_ST_IDLE:
        begin
          if (accept)
          begin
            state_q <= DCC_ST_PULSE;
            open_q <= acc_open;
            close_q <= acc_close;
            target_q <= acc_close ? DCC_POS_ON : DCC_POS_OFF;
          end
        end
        DCC_ST_PULSE:
        begin
          if (pulse_end)
          begin
            state_q <= DCC_ST_IDLE;
            open_q <= 1'b0;
            close_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= DCC_ST_IDLE;
          open_q <= 1'b0;
          close_q <= 1'b0;
        end
      endcase
    end
  end

  // Accept and refuse strobes
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      acc_q <= 1'b0;
      ref_q <= 1'b0;
    end
    else if (clock_en)
    begin
      acc_q <= accept;
      ref_q <= (local_cmd.valid | remote_cmd.valid) & ~accept;
    end
  end

  // Enhanced models: position must reach the target within the operating time
  dcc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_optime_tmr (
    .clock(clock), .clock_en(clock_en), .rst_n(rst_n_q),
    .start(accept & enhanced_model), .stop(pos_q == target_q),
    .limit_ms(dcc_clamp_ms(max_operating_ms, `DCC_OPTIME_MIN_MS, `DCC_OPTIME_MAX_MS,
                           `DCC_OPTIME_DEF_MS)),
    .running(optime_running), .elapsed_ms(), .expired(optime_exp)
  );

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      err_q <= 1'b0;
    end
    else if (clock_en)
    begin
      err_q <= optime_exp;
    end
  end

  // Position filter: a clean reading is taken at once, a missing one only after timeout
  assign raw_pos = dcc_pos_decode(closed_position_input, open_position_input);

  dcc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_inter_tmr (
    .clock(clock), .clock_en(clock_en), .rst_n(rst_n_q),
    .start((raw_pos == DCC_POS_INTERMEDIATE) & (raw_prev_q != DCC_POS_INTERMEDIATE)),
    .stop(raw_pos != DCC_POS_INTERMEDIATE),
    .limit_ms(dcc_clamp_ms(max_intermediate_ms, `DCC_INTER_MIN_MS, `DCC_INTER_MAX_MS,
                           `DCC_INTER_DEF_MS)),
    .running(), .elapsed_ms(), .expired(inter_exp)
  );

  always_comb
  begin
    pos_d = pos_q;
    if (raw_pos != DCC_POS_INTERMEDIATE)
    begin
      pos_d = raw_pos;
    end
    else if (inter_exp)
    begin
      pos_d = DCC_POS_INTERMEDIATE;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pos_q <= DCC_POS_INTERMEDIATE;
      raw_prev_q <= DCC_POS_INTERMEDIATE;
      opened_q <= 1'b0;
      closed_q <= 1'b0;
      event_q <= 1'b0;
      event_code_q <= DCC_POS_INTERMEDIATE;
    end
    else if (clock_en)
    begin
      raw_prev_q <= raw_pos;
      pos_q <= pos_d;
      opened_q <= (pos_d == DCC_POS_OFF);
      closed_q <= (pos_d == DCC_POS_ON);
      event_q <= (pos_d != pos_q);
      if (pos_d != pos_q)
      begin
        event_code_q <= pos_d;
      end
    end
  end

  // Operation pulse restarts on each move into a clean end position
  dcc_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_oper_tmr (
    .clock(clock), .clock_en(clock_en), .rst_n(rst_n_q),
    .start((pos_d != pos_q) & ((pos_d == DCC_POS_OFF) | (pos_d == DCC_POS_ON))),
    .stop(1'b0), .limit_ms(`DCC_OPER_PULSE_MS),
    .running(oper_running), .elapsed_ms(), .expired()
  );

  assign op_rise = oper_running & ~op_prev_q;

  // Counter: an increment in the reset cycle is kept, so the count reads one
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      op_prev_q <= 1'b0;
      count_q <= `DCC_COUNT_RST;
    end
    else if (clock_en)
    begin
      op_prev_q <= oper_running;
      if (counter_reset)
      begin
        count_q <= op_rise ? 32'h00000001 : `DCC_COUNT_RST;
      end
      else if (op_rise)
      begin
        count_q <= count_q + 32'h00000001;
      end
    end
  end

  assign open_command_pulse = open_q;
  assign close_command_pulse = close_q;
  assign operation_pulse = oper_running;
  assign opened_indication = opened_q;
  assign closed_indication = closed_q;
  assign position_state_code = pos_q;
  assign position_event = event_q;
  assign position_event_code = event_code_q;
  assign cmd_accepted = acc_q;
  assign cmd_refused = ref_q;
  assign invalid_position_error = err_q;
  assign operation_count = count_q;

  default clocking dcc_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n_q);

  property p_open_pulse;
    acc_open |=> open_command_pulse && !close_command_pulse ##1 open_command_pulse[*7];
  endproperty
  a_open_pulse: assert property (p_open_pulse) else $error("open pulse not started");
  property p_close_pulse;
    acc_close |=> close_command_pulse && !open_command_pulse ##1 close_command_pulse[*7];
  endproperty
  a_close_pulse: assert property (p_close_pulse) else $error("close pulse not started");
  property p_oper_len;
    $rose(operation_pulse) |-> operation_pulse[*8];
  endproperty
  a_oper_len: assert property (p_oper_len) else $error("operation pulse too short");
  property p_count_inc;
    clock_en && op_rise && !counter_reset |=> operation_count == $past(operation_count) + 1;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter missed operation");
  property p_count_clr;
    clock_en && counter_reset |=> operation_count <= 32'h00000001;
  endproperty
  a_count_clr: assert property (p_count_clr) else $error("counter not cleared");
  property p_indic;
    opened_indication == (position_state_code == DCC_POS_OFF)
      && closed_indication == (position_state_code == DCC_POS_ON);
  endproperty
  a_indic: assert property (p_indic) else $error("indication disagrees with code");
  property p_event;
    position_state_code != $past(position_state_code)
      |-> position_event && position_event_code == position_state_code;
  endproperty
  a_event: assert property (p_event) else $error("position change without event");
  property p_origin;
    accept |-> (local_cmd.valid ? local_permit : remote_permit);
  endproperty
  a_origin: assert property (p_origin) else $error("command without origin permit");
  property p_dir;
    (acc_open |-> open_permit) and (acc_close |-> close_permit);
  endproperty
  a_dir: assert property (p_dir) else $error("command without direction permit");
  property p_inhibit;
    inhibit_input |-> !accept ##1 !$rose(open_command_pulse | close_command_pulse);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("command taken while inhibited");
  property p_err_model;
    $rose(optime_running) |-> $past(enhanced_model);
  endproperty
  a_err_model: assert property (p_err_model) else $error("operating timer in direct model");

  c_open: cover property (acc_open ##[1:20] $fell(open_command_pulse));
  c_close: cover property (acc_close ##1 close_command_pulse);
  c_event: cover property (position_event && position_event_code == DCC_POS_BAD);
  c_refused: cover property (cmd_refused && inhibit_input);
endmodule : dcc_top
`default_nettype wire

/* File: core/dcc_defines.svh */
// Constants of the disconnector control block
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_CLK_PERIOD_NS 10
`define DCC_MS_NS 1000000
`define DCC_OPER_PULSE_MS 16'h0096
`define DCC_PULSE_MIN_MS 16'h0064
`define DCC_PULSE_MAX_MS 16'hEA60
`define DCC_PULSE_DEF_MS 16'h03E8
`define DCC_INTER_MIN_MS 16'h0014
`define DCC_INTER_MAX_MS 16'hEA60
`define DCC_INTER_DEF_MS 16'h2710
`define DCC_OPTIME_MIN_MS 16'h000A
`define DCC_OPTIME_MAX_MS 16'hEA60
`define DCC_OPTIME_DEF_MS 16'h2710
`define DCC_COUNT_RST 32'h00000000
`endif

/* File: core/dcc_pkg.sv */
// Types and helper functions of the disconnector control block
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_POS_INTERMEDIATE,
    DCC_POS_OFF,
    DCC_POS_ON,
    DCC_POS_BAD
  } dcc_pos_t;

  typedef enum logic {
    DCC_ST_IDLE,
    DCC_ST_PULSE
  } dcc_state_t;

  typedef struct packed {
    logic valid;
    logic close;
  } dcc_cmd_t;

  // A zero setting selects the default; others are held inside the range
  function automatic logic [15:0] dcc_clamp_ms(input logic [15:0] v, input logic [15:0] lo,
                                               input logic [15:0] hi, input logic [15:0] def);
    logic [15:0] r;
    r = v;
    if (v == 16'h0000)
    begin
      r = def;
    end
    else if (v < lo)
    begin
      r = lo;
    end
    else if (v > hi)
    begin
      r = hi;
    end
    return r;
  endfunction : dcc_clamp_ms

  function automatic dcc_pos_t dcc_pos_decode(input logic closed_in, input logic open_in);
    return dcc_pos_t'({closed_in, open_in});
  endfunction : dcc_pos_decode
endpackage : dcc_pkg

/* File: core/dcc_ms_timer.sv */
// Millisecond interval timer with its own restartable prescaler
`timescale 1ns/1ps
`default_nettype none
module dcc_ms_timer #(
  parameter int unsigned CYC_PER_MS = 100000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic clock_en,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] limit_ms,
  // Status
  output logic running,
  output logic [15:0] elapsed_ms,
  output logic expired
);
  logic running_q;
  logic expired_q;
  logic [15:0] elapsed_q;
  logic [31:0] presc_q;

  // Prescaler restarts with each start so an interval is exact to one cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running_q <= 1'b0;
      expired_q <= 1'b0;
      elapsed_q <= 16'h0000;
      presc_q <= 32'h00000000;
    end
    else if (clock_en)
    begin
      expired_q <= 1'b0;
      if (start)
      begin
        running_q <= 1'b1;
        elapsed_q <= 16'h0000;
        presc_q <= 32'h00000000;
      end
      else if (stop)
      begin
        running_q <= 1'b0;
      end
      else if (running_q)
      begin
        if (presc_q == CYC_PER_MS - 1)
        begin
          presc_q <= 32'h00000000;
          elapsed_q <= elapsed_q + 16'h0001;
          if ({1'b0, elapsed_q} + 17'h00001 >= {1'b0, limit_ms})
          begin
            running_q <= 1'b0;
            expired_q <= 1'b1;
          end
        end
        else
        begin
          presc_q <= presc_q + 32'h00000001;
        end
      end
    end
  end

  assign running = running_q;
  assign elapsed_ms = elapsed_q;
  assign expired = expired_q;
endmodule : dcc_ms_timer
`default_nettype wire

/* File: verif/dcc_contact_model.sv */
// Behavioural model of the disconnector contacts seen by the control block
`timescale 1ns/1ps
`default_nettype none
module dcc_contact_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Commands from the block, behaviour knobs from the bench
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic stuck,
  input wire logic [15:0] travel_cyc,
  input wire logic ovr_en,
  input wire logic [1:0] ovr_val,
  // Contacts
  output logic open_pos,
  output logic closed_pos
);
  logic [1:0] pos_q;
  logic [1:0] tgt_q;
  logic [1:0] cmd_q;
  logic [15:0] travel_q;
  // Edge detect: the command pulse outlasts the travel and must not restart it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_q <= 2'h0;
      tgt_q <= 2'h0;
      cmd_q <= 2'h0;
      travel_q <= 16'h0000;
    end
    else
    begin
      cmd_q <= {close_cmd, open_cmd};
      if (!stuck && ((open_cmd && !cmd_q[0]) || (close_cmd && !cmd_q[1])))
      begin
        tgt_q <= close_cmd ? 2'h2 : 2'h1;
        travel_q <= travel_cyc;
        pos_q <= 2'h0;
      end
      else if (travel_q != 16'h0000)
      begin
        travel_q <= travel_q - 16'h0001;
        if (travel_q == 16'h0001) pos_q <= tgt_q;
      end
    end
  end
  // The bench may override the contacts to reach the bad and intermediate codes
  assign {closed_pos, open_pos} = ovr_en ? ovr_val : pos_q;
endmodule : dcc_contact_model
`default_nettype wire

/* File: verif/dcc_top_tb_top.sv */
// Self-checking testbench of the disconnector control block
`timescale 1ns/1ps
`default_nettype none
module dcc_top_tb_top
  import dcc_pkg::*;
;
  logic clock = 1'b0;
  logic clock_en = 1'b1;
  logic arst_n = 1'b0;
  dcc_cmd_t local_cmd = '0;
  dcc_cmd_t remote_cmd = '0;
  logic local_permit = 1'b0;
  logic remote_permit = 1'b0;
  logic open_permit = 1'b0;
  logic close_permit = 1'b0;
  logic inhibit_input = 1'b0;
  logic [15:0] pulse_duration_ms = 16'h00C8;
  logic enhanced_model = 1'b1;
  logic counter_reset = 1'b0;
  logic stuck = 1'b1;
  logic ovr_en = 1'b0;
  logic [1:0] ovr_val = 2'h2;
  logic open_position_input;
  logic closed_position_input;
  logic open_command_pulse;
  logic close_command_pulse;
  logic operation_pulse;
  logic opened_indication;
  logic closed_indication;
  dcc_pos_t position_state_code;
  logic position_event;
  dcc_pos_t position_event_code;
  logic cmd_accepted;
  logic cmd_refused;
  logic invalid_position_error;
  logic [31:0] operation_count;
  int err_total = 0;
  int num_checks = 0;

  always #5 clock = ~clock;

  // Ten cycles per millisecond keeps every timed interval short
  dcc_top #(.CYC_PER_MS(10)) dut (.clock, .clock_en, .arst_n, .local_cmd, .remote_cmd,
    .local_permit, .remote_permit, .open_permit, .close_permit, .inhibit_input,
    .open_position_input, .closed_position_input, .pulse_duration_ms,
    .max_intermediate_ms(16'h0014), .max_operating_ms(16'h000A), .enhanced_model,
    .counter_reset, .open_command_pulse, .close_command_pulse, .operation_pulse,
    .opened_indication, .closed_indication, .position_state_code, .position_event,
    .position_event_code, .cmd_accepted, .cmd_refused, .invalid_position_error,
    .operation_count);

  dcc_contact_model partner (.clock, .rst_n(arst_n), .open_cmd(open_command_pulse),
    .close_cmd(close_command_pulse), .stuck, .travel_cyc(16'h001E), .ovr_en, .ovr_val,
    .open_pos(open_position_input), .closed_pos(closed_position_input));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // Timed intervals may deviate by 5 percent or 15 ms, whichever is larger
  task automatic chk_time(input string nm, input int exp, input int got);
    int t;
    t = (exp / 20 > 150) ? exp / 20 : 150;
    num_checks++;
    if (got < exp - t || got > exp + t)
    begin
      err_total++;
      $display("FAIL %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_time

  function automatic logic pick(input int k);
    case (k)
      0: return open_command_pulse;
      1: return close_command_pulse;
      2: return operation_pulse;
      3: return position_state_code !== DCC_POS_INTERMEDIATE;
      default: return invalid_position_error;
    endcase
  endfunction : pick

  // Counts cycles while the selected signal keeps the given level
  task automatic run_len(input int k, input logic lvl, input int lim, output int n);
    n = 0;
    while (pick(k) === lvl && n < lim)
    begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : run_len

  // Permit bits are local, remote, open, close, inhibit
  task automatic issue(input logic rem, input logic cl, input logic [4:0] pm, input logic acc);
    @(posedge clock);
    {local_permit, remote_permit, open_permit, close_permit, inhibit_input} <= pm;
    if (rem) remote_cmd <= '{1'b1, cl};
    else local_cmd <= '{1'b1, cl};
    @(posedge clock);
    local_cmd <= '0;
    remote_cmd <= '0;
    #1;
    chk("cmd_accepted", acc, cmd_accepted);
    chk("cmd_refused", !acc, cmd_refused);
  endtask : issue

  task automatic t_open_stuck;
    int n;
    int e;
    issue(1'b0, 1'b0, 5'b10100, 1'b1);
    chk("close_command_pulse", 1'b0, close_command_pulse);
    fork
      run_len(0, 1'b1, 80000, n);
      run_len(4, 1'b0, 3000, e);
    join
    chk_time("open pulse cycles", 2000, n);
    chk_time("invalid position delay", 100, e);
  endtask : t_open_stuck

  task automatic t_close_move;
    int n;
    int w;
    int m;
    int e;
    stuck <= 1'b0;
    issue(1'b1, 1'b1, 5'b01010, 1'b1);
    fork
      run_len(1, 1'b1, 80000, n);
      begin
        run_len(2, 1'b0, 200, w);
        run_len(2, 1'b1, 80000, m);
      end
      run_len(4, 1'b0, 2500, e);
    join
    chk_time("close pulse cycles", 1000, n);
    chk_time("operation pulse cycles", 1500, m);
    chk("invalid_position_error", 32'd2500, e);
    chk("position_state_code", DCC_POS_ON, position_state_code);
    chk("closed_indication", 1'b1, closed_indication);
    chk("opened_indication", 1'b0, opened_indication);
    chk("position_event_code", DCC_POS_ON, position_event_code);
    chk("operation_count", 32'h00000001, operation_count);
  endtask : t_close_move

  task automatic t_refuse;
    logic [6:0] tbl [5] = '{7'b0001110, 7'b1010110, 7'b0011010, 7'b0111100, 7'b0111111};
    foreach (tbl[i]) issue(tbl[i][6], tbl[i][5], tbl[i][4:0], 1'b0);
    chk("command pulses", 2'h0, {open_command_pulse, close_command_pulse});
  endtask : t_refuse

  // A clear request seen while the enable is low must not act until it rises
  task automatic t_counter_reset;
    @(posedge clock);
    clock_en <= 1'b0;
    counter_reset <= 1'b1;
    @(posedge clock);
    #1;
    chk("frozen operation_count", 32'h00000001, operation_count);
    @(posedge clock);
    clock_en <= 1'b1;
    @(posedge clock);
    counter_reset <= 1'b0;
    #1;
    chk("operation_count", 32'h00000000, operation_count);
  endtask : t_counter_reset

  // Direct model: no operating-time supervision, shortest pulse runs to its end
  task automatic t_direct;
    int e;
    int n;
    enhanced_model <= 1'b0;
    pulse_duration_ms <= 16'h0064;
    issue(1'b0, 1'b0, 5'b10100, 1'b1);
    fork
      run_len(0, 1'b1, 20000, n);
      run_len(4, 1'b0, 300, e);
    join
    chk("direct invalid_position_error", 32'd300, e);
    chk_time("minimum open pulse cycles", 1000, n);
  endtask : t_direct

  task automatic t_codes;
    dcc_pos_t seq [3] = '{DCC_POS_OFF, DCC_POS_BAD, DCC_POS_ON};
    int w;
    ovr_en <= 1'b1;
    foreach (seq[i])
    begin
      @(posedge clock);
      ovr_val <= seq[i];
      @(posedge clock);
      #1;
      chk("position_state_code", seq[i], position_state_code);
      chk("position_event", 1'b1, position_event);
      chk("position_event_code", seq[i], position_event_code);
      chk("opened_indication", seq[i] == DCC_POS_OFF, opened_indication);
      chk("closed_indication", seq[i] == DCC_POS_ON, closed_indication);
      repeat (20) @(posedge clock);
    end
    // The on code retriggers a running operation pulse, so it adds no count
    chk("operation_count", 32'h00000001, operation_count);
    @(posedge clock);
    ovr_val <= 2'h0;
    @(posedge clock);
    #1;
    chk("held position_state_code", DCC_POS_ON, position_state_code);
    run_len(3, 1'b1, 1000, w);
    chk_time("intermediate report delay", 200, w);
  endtask : t_codes

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (30000) @(posedge clock);
    err_total++;
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("position_state_code", DCC_POS_INTERMEDIATE, position_state_code);
    chk("outputs after reset", 32'h0, {28'h0000000, opened_indication, closed_indication,
      open_command_pulse, close_command_pulse});
    chk("count after reset", 32'h0, operation_count);
    t_open_stuck();
    t_close_move();
    t_refuse();
    t_counter_reset();
    t_codes();
    t_direct();
    conclude();
  end
endmodule : dcc_top_tb_top
`default_nettype wire
